// ### asx_map.svh
// register map, field positions, reset values and timing counts
`ifndef ASX_MAP_SVH
`define ASX_MAP_SVH
`define ASX_IDX_INTERVAL 16'hFF6B
`define ASX_IDX_MODE 16'hFF60
`define ASX_IDX_CTRL 16'hFF61
`define ASX_IDX_PTR 16'hFF62
`define ASX_IDX_SHIFT 16'hFF63
`define ASX_IDX_STATUS 16'hFF64
`define ASX_IDX_RAM_LO 16'hFAC0
`define ASX_IDX_RAM_HI 16'hFADF
`define ASX_INTERVAL_RST 8'h00
`define ASX_BIT_ICTRL 7
`define ASX_FLD_IVAL_LSB 0
`define ASX_FLD_IVAL_MSB 4
`define ASX_BIT_SIE 7
`define ASX_BIT_AUTO 6
`define ASX_BIT_HALF 0
`define ASX_BIT_RXEN 5
`define ASX_BIT_ACTIVE 3
`define ASX_BIT_RELOAD 2
`define ASX_BIT_IRQ 0
`define ASX_GAP_UNIT 12'h040
`define ASX_GAP_BASE 12'h020
`define ASX_MIN_FALLS 2'h2
`define ASX_LAST_BIT 3'h7
`endif

// ### asx_pkg.sv
// types shared by the auto serial transfer engine
`default_nettype none
package asx_pkg;
  typedef enum logic [2:0] {
    ASX_IDLE = 3'b000,
    ASX_LOAD = 3'b001,
    ASX_WAIT = 3'b010,
    ASX_SHIFT = 3'b011,
    ASX_STORE = 3'b100
  } asx_state_t;
endpackage
`default_nettype wire

// ### asx_auto_xfer.sv
// automatic buffer-to-serial transfer engine with apb registers
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "asx_map.svh"
// Summary of operation
// - gap set by the programmed interval field, (field + 1) * 64 + 32 base ticks
// - gap never shorter than two serial periods
// - control bit enables programmed interval timing
// - busy handshake ignored under interval control
// - trigger write only starts, value discarded
// - copy buffer byte to shifter, shift out
// - received byte stored at current pointer
// - decrement pointer, end after address zero
// - clear active flag at termination
// - raise completion flag after final byte
// - basic mode (auto bit clear) exchanges no bytes, trigger needs both enable and auto bits
// - strobe and busy pins released
// - gap inserted between bytes, none after the final byte
// - serial output low while inactive
// - store, decrement, then load next byte
// - interval base is main clock or half
module asx_auto_xfer
  import asx_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sck_in,
  input wire logic si_in,
  output logic serial_out_pin,
  output logic strobe_pin_out,
  output logic strobe_pin_oe,
  output logic busy_pin_out,
  output logic busy_pin_oe
);
  logic [15:0] idx;
  logic wr_acc;
  logic setup;
  logic ram_hit;
  logic known;
  logic [7:0] ram [0:31];
  logic [7:0] ram_wdata;
  logic [4:0] ram_waddr;
  logic ram_we;

  // register state
  logic [7:0] interval_reg, interval_next;
  logic [7:0] mode_reg, mode_next;
  logic rx_en_reg, rx_en_next;
  logic reload_reg, reload_next;
  logic active_reg, active_next;
  logic irq_reg, irq_next;
  logic [4:0] ptr_reg, ptr_next;
  logic [31:0] prdata_reg, prdata_next;
  logic err_reg, err_next;

  // engine state
  asx_state_t state_reg, state_next;
  logic [7:0] sh_reg, sh_next;
  logic so_reg, so_next;
  logic [2:0] bit_reg, bit_next;
  logic [11:0] gap_reg, gap_next;
  logic [1:0] falls_reg, falls_next;
  logic first_reg, first_next;
  logic div_reg, div_next;

  // link synchronisers and edge finder
  logic sck_s1_reg, sck_s2_reg, sck_s3_reg;
  logic si_s1_reg, si_s2_reg;
  logic sck_rise, sck_fall;
  logic base_tick;
  logic trigger;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      // link clock idles high, no false edge after reset
      sck_s1_reg <= 1'b1;
      sck_s2_reg <= 1'b1;
      sck_s3_reg <= 1'b1;
      si_s1_reg <= 1'b0;
      si_s2_reg <= 1'b0;
    end else begin
      sck_s1_reg <= sck_in;
      sck_s2_reg <= sck_s1_reg;
      sck_s3_reg <= sck_s2_reg;
      si_s1_reg <= si_in;
      si_s2_reg <= si_s1_reg;
    end
  end

  assign sck_rise = sck_s2_reg & ~sck_s3_reg;
  assign sck_fall = ~sck_s2_reg & sck_s3_reg;

  assign base_tick = mode_reg[`ASX_BIT_HALF] ? div_reg : 1'b1;

  assign idx = paddr[17:2];
  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pwrite;
  assign ram_hit = (idx >= `ASX_IDX_RAM_LO) && (idx <= `ASX_IDX_RAM_HI);
  assign known = ram_hit || (idx == `ASX_IDX_INTERVAL) || (idx == `ASX_IDX_MODE) ||
                 (idx == `ASX_IDX_CTRL) || (idx == `ASX_IDX_PTR) ||
                 (idx == `ASX_IDX_SHIFT) || (idx == `ASX_IDX_STATUS);

  assign trigger = wr_acc && (idx == `ASX_IDX_SHIFT) && (state_reg == ASX_IDLE) &&
                   mode_reg[`ASX_BIT_SIE] && mode_reg[`ASX_BIT_AUTO];

  always_comb begin
    interval_next = interval_reg;
    mode_next = mode_reg;
    rx_en_next = rx_en_reg;
    reload_next = reload_reg;
    active_next = active_reg;
    irq_next = irq_reg;
    ptr_next = ptr_reg;
    prdata_next = prdata_reg;
    err_next = err_reg;
    state_next = state_reg;
    sh_next = sh_reg;
    so_next = so_reg;
    bit_next = bit_reg;
    gap_next = gap_reg;
    falls_next = falls_reg;
    first_next = first_reg;
    div_next = ~div_reg;
    ram_we = 1'b0;
    ram_waddr = ptr_reg;
    ram_wdata = sh_reg;

    // read data captured in setup, answered in access
    if (setup) begin
      err_next = ~known;
      prdata_next = 32'h0000_0000;
      if (ram_hit) begin
        prdata_next[7:0] = ram[idx[4:0]];
      end else begin
        case (idx)
          `ASX_IDX_INTERVAL: prdata_next[7:0] = interval_reg;
          `ASX_IDX_MODE: prdata_next[7:0] = mode_reg;
          `ASX_IDX_CTRL: begin
            prdata_next[`ASX_BIT_RXEN] = rx_en_reg;
            prdata_next[`ASX_BIT_RELOAD] = reload_reg;
            prdata_next[`ASX_BIT_ACTIVE] = active_reg;
          end
          `ASX_IDX_PTR: prdata_next[4:0] = ptr_reg;
          `ASX_IDX_SHIFT: prdata_next[7:0] = sh_reg;
          `ASX_IDX_STATUS: prdata_next[`ASX_BIT_IRQ] = irq_reg;
          default: prdata_next = 32'h0000_0000;
        endcase
      end
    end

    if (wr_acc) begin
      if (ram_hit) begin
        ram_we = 1'b1;
        ram_waddr = idx[4:0];
        ram_wdata = pwdata[7:0];
      end
      case (idx)
        `ASX_IDX_INTERVAL: interval_next = pwdata[7:0];
        `ASX_IDX_MODE: mode_next = pwdata[7:0];
        `ASX_IDX_CTRL: begin
          rx_en_next = pwdata[`ASX_BIT_RXEN];
          reload_next = pwdata[`ASX_BIT_RELOAD];
        end
        `ASX_IDX_PTR: ptr_next = pwdata[4:0];
        `ASX_IDX_STATUS: begin
          if (pwdata[`ASX_BIT_IRQ]) begin
            irq_next = 1'b0;
          end
        end
        default: ;
      endcase
    end

    if (base_tick && gap_reg != 12'h000) begin
      gap_next = gap_reg - 12'h001;
    end

    case (state_reg)
      ASX_IDLE: begin
        if (trigger) begin
          active_next = 1'b1;
          first_next = 1'b1;
          // no stale bit from the last run before the first fall
          so_next = 1'b0;
          gap_next = 12'h000;
          state_next = ASX_LOAD;
        end
      end
      ASX_LOAD: begin
        sh_next = ram[ptr_reg];
        state_next = ASX_WAIT;
      end
      ASX_WAIT: begin
        if (sck_fall && falls_reg != 2'h3) begin
          falls_next = falls_reg + 2'h1;
        end
        if (sck_fall && gap_reg == 12'h000 && (first_reg || falls_reg >= `ASX_MIN_FALLS)) begin
          so_next = sh_reg[7];
          bit_next = 3'h0;
          first_next = 1'b0;
          state_next = ASX_SHIFT;
        end
      end
      ASX_SHIFT: begin
        if (sck_rise) begin
          sh_next = {sh_reg[6:0], si_s2_reg};
          bit_next = bit_reg + 3'h1;
          if (bit_reg == `ASX_LAST_BIT) begin
            state_next = ASX_STORE;
          end
        end else if (sck_fall) begin
          so_next = sh_reg[7];
        end
      end
      ASX_STORE: begin
        // store first, then pointer, then load
        if (rx_en_reg) begin
          ram_we = 1'b1;
          ram_waddr = ptr_reg;
          ram_wdata = sh_reg;
        end
        falls_next = 2'h0;
        if (ptr_reg == 5'h00) begin
          active_next = 1'b0;
          irq_next = 1'b1;
          state_next = ASX_IDLE;
        end else begin
          ptr_next = ptr_reg - 5'h01;
          state_next = ASX_LOAD;
          if (interval_reg[`ASX_BIT_ICTRL]) begin
            gap_next = ({7'h00, interval_reg[`ASX_FLD_IVAL_MSB:`ASX_FLD_IVAL_LSB]} + 12'h001)
                       * `ASX_GAP_UNIT + `ASX_GAP_BASE;
          end else begin
            gap_next = 12'h000;
          end
        end
      end
      default: state_next = ASX_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      interval_reg <= `ASX_INTERVAL_RST;
      mode_reg <= 8'h00;
      rx_en_reg <= 1'b0;
      reload_reg <= 1'b0;
      active_reg <= 1'b0;
      irq_reg <= 1'b0;
      ptr_reg <= 5'h00;
      prdata_reg <= 32'h0000_0000;
      err_reg <= 1'b0;
      state_reg <= ASX_IDLE;
      sh_reg <= 8'h00;
      so_reg <= 1'b0;
      bit_reg <= 3'h0;
      gap_reg <= 12'h000;
      falls_reg <= 2'h0;
      first_reg <= 1'b0;
      div_reg <= 1'b0;
    end else begin
      interval_reg <= interval_next;
      mode_reg <= mode_next;
      rx_en_reg <= rx_en_next;
      reload_reg <= reload_next;
      active_reg <= active_next;
      irq_reg <= irq_next;
      ptr_reg <= ptr_next;
      prdata_reg <= prdata_next;
      err_reg <= err_next;
      state_reg <= state_next;
      sh_reg <= sh_next;
      so_reg <= so_next;
      bit_reg <= bit_next;
      gap_reg <= gap_next;
      falls_reg <= falls_next;
      first_reg <= first_next;
      div_reg <= div_next;
    end
  end

  // buffer ram, engine store wins over bus write
  always_ff @(posedge core_clk) begin
    if (ram_we) begin
      ram[ram_waddr] <= ram_wdata;
    end
  end

  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = psel & penable & err_reg;
  assign serial_out_pin = active_reg & so_reg;
  assign strobe_pin_out = 1'b0;
  assign strobe_pin_oe = 1'b0;
  assign busy_pin_out = 1'b0;
  assign busy_pin_oe = 1'b0;
endmodule // asx_auto_xfer
`default_nettype wire

// ### asx_props.sv
// port checker for the auto transfer engine
`timescale 1ns/1ps
`default_nettype none
`include "asx_map.svh"
module asx_props (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sck_in,
  input wire logic serial_out_pin,
  input wire logic strobe_pin_oe,
  input wire logic busy_pin_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire logic [15:0] idx = paddr[17:2];
  wire logic acc = psel && penable;
  wire logic hit = idx == `ASX_IDX_INTERVAL || (idx >= `ASX_IDX_MODE && idx <= `ASX_IDX_STATUS)
    || (idx >= `ASX_IDX_RAM_LO && idx <= `ASX_IDX_RAM_HI);
  logic [7:0] ival_reg;
  logic [3:0] fall_reg;
  logic sck_reg;
  // cycles since the last link clock fall
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ival_reg <= `ASX_INTERVAL_RST;
      fall_reg <= 4'hF;
      sck_reg <= 1'b1;
    end else begin
      sck_reg <= sck_in;
      if (sck_reg && !sck_in) fall_reg <= 4'h0;
      else if (fall_reg != 4'hF) fall_reg <= fall_reg + 4'h1;
      if (acc && pwrite && idx == `ASX_IDX_INTERVAL) ival_reg <= pwdata[7:0];
    end
  end
  property p_rdy; pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready low");
  property p_err; pslverr |-> acc; endproperty
  a_err: assert property (p_err) else $error("error outside access");
  property p_unmap; acc && !hit |-> pslverr; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped not refused");
  property p_map; acc && hit |-> !pslverr; endproperty
  a_map: assert property (p_map) else $error("mapped refused");
  property p_hi; acc && !pwrite |-> prdata[31:8] == 24'h000000; endproperty
  a_hi: assert property (p_hi) else $error("upper read bits set");
  property p_ival; acc && !pwrite && idx == `ASX_IDX_INTERVAL |-> prdata[7:0] == ival_reg; endproperty
  a_ival: assert property (p_ival) else $error("interval readback");
  property p_bit; $rose(serial_out_pin) |-> fall_reg <= 4'h6; endproperty
  a_bit: assert property (p_bit) else $error("bit not on clock fall");
  property p_pins; !strobe_pin_oe && !busy_pin_oe; endproperty
  a_pins: assert property (p_pins) else $error("pins driven");
endmodule // asx_props
bind asx_auto_xfer asx_props u_asx_props (
  .core_clk(core_clk),
  .rst_n(rst_n),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .sck_in(sck_in),
  .serial_out_pin(serial_out_pin),
  .strobe_pin_oe(strobe_pin_oe),
  .busy_pin_oe(busy_pin_oe)
);
`default_nettype wire

// ### asx_peer.sv
// serial peer: link clock, data source, capture
`timescale 1ns/1ps
`default_nettype none
module asx_peer (
  input wire logic run,
  input wire logic so,
  output logic sck,
  output logic si,
  output logic [7:0] got
);
  localparam logic [7:0] TXP = 8'hA5;
  int n;
  initial begin
    sck = 1'b1;
    si = 1'b0;
    got = 8'h00;
    n = 0;
    forever begin
      #24;
      if (!run) begin
        sck = 1'b1;
        si = ~si;
        n = 0;
      end else begin
        sck = ~sck;
        if (!sck) si = TXP[7 - n % 8];
        else if (n < 8) got = {got[6:0], so};
        if (sck) n++;
      end
    end
  end
endmodule // asx_peer
`default_nettype wire

// ### tb_asx_auto_xfer.sv
// testbench for the auto transfer engine
`timescale 1ns/1ps
`default_nettype none
`include "asx_map.svh"
module tb_asx_auto_xfer;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [17:0] paddr = 18'h00000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sck_in;
  logic si_in;
  logic serial_out_pin;
  logic run = 1'b0;
  logic [7:0] got;
  logic [31:0] q;
  logic q_err;
  int failures = 0;
  int checks = 0;
  int cyc = 0;
  logic [7:0] ivals [4] = '{8'h82, 8'h81, 8'h00, 8'h9F};
  logic [7:0] modes [4] = '{8'hC0, 8'hC1, 8'hC0, 8'hC0};
  asx_auto_xfer u_asx_auto_xfer (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .sck_in, .si_in, .serial_out_pin, .strobe_pin_out(), .strobe_pin_oe(),
    .busy_pin_out(), .busy_pin_oe());
  asx_peer u_asx_peer (.run(run), .so(serial_out_pin), .sck(sck_in), .si(si_in), .got(got));
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      results();
    end
  end
  task automatic results();
    if (failures == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [15:0] i, input logic [7:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    q = prdata;
    q_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cmp(input logic [31:0] a, input logic [31:0] e);
    checks++;
    if (a !== e) begin
      failures++;
      $display("MISMATCH %0t got %h exp %h", $time, a, e);
    end
  endtask
  task automatic chk(input logic [15:0] i, input logic [7:0] e);
    xfer(1'b0, i, 8'h00);
    cmp(q, {24'h000000, e});
  endtask
  task automatic run_case(input int c);
    int k;
    int t0;
    int lo;
    k = modes[c][0] ? 2 : 1;
    lo = 144 + (ivals[c][7] ? ((ivals[c][4:0] + 1) * 64 + 28) * k : 0);
    xfer(1'b1, `ASX_IDX_RAM_LO + 16'h0001, 8'h3C);
    xfer(1'b1, `ASX_IDX_RAM_LO, 8'hC3);
    xfer(1'b1, `ASX_IDX_PTR, 8'h01);
    xfer(1'b1, `ASX_IDX_MODE, modes[c]);
    xfer(1'b1, `ASX_IDX_CTRL, 8'h20);
    xfer(1'b1, `ASX_IDX_INTERVAL, ivals[c]);
    xfer(1'b1, `ASX_IDX_SHIFT, 8'hFF);
    t0 = cyc;
    run <= 1'b1;
    chk(`ASX_IDX_CTRL, 8'h28);
    do xfer(1'b0, `ASX_IDX_CTRL, 8'h00); while (q[3] !== 1'b0);
    cmp({31'h0, (cyc - t0) >= lo && (cyc - t0) <= lo + 96}, 32'h1);
    run <= 1'b0;
    cmp(q, 32'h20);
    cmp({31'h0, serial_out_pin}, 32'h0);
    cmp({24'h000000, got}, 32'h3C);
    chk(`ASX_IDX_RAM_LO + 16'h0001, 8'hA5);
    chk(`ASX_IDX_PTR, 8'h00);
    chk(`ASX_IDX_STATUS, 8'h01);
    xfer(1'b1, `ASX_IDX_STATUS, 8'h01);
    chk(`ASX_IDX_STATUS, 8'h00);
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    chk(`ASX_IDX_INTERVAL, `ASX_INTERVAL_RST);
    cmp({31'h0, q_err}, 32'h0);
    xfer(1'b1, 16'h0000, 8'h55);
    cmp({31'h0, q_err}, 32'h1);
    chk(16'h0000, 8'h00);
    xfer(1'b1, `ASX_IDX_MODE, 8'h00);
    xfer(1'b1, `ASX_IDX_SHIFT, 8'hFF);
    chk(`ASX_IDX_CTRL, 8'h00);
    for (int c = 0; c < 4; c++) run_case(c);
    results();
  end
endmodule // tb_asx_auto_xfer
`default_nettype wire
